/* srd_map.svh */
// srd_map.svh: offsets, codes and timing counts of the serdes datapath.
// assumes inclusion by bare name from the design files.
`ifndef SRD_MAP_SVH
`define SRD_MAP_SVH
`define SRD_MCLK_KHZ  250000
`define SRD_SYS_KHZ   30720
`define SRD_SYS_HALF  3'(`SRD_MCLK_KHZ / (2 * `SRD_SYS_KHZ))
`define SRD_MISS_WORDS 7
`define SRD_MISS_CYC  8'(`SRD_MISS_WORDS * 2 * 10)
`define SRD_LAST_BIT  4'h9
`define SRD_K30_7     9'h1fe
`define SRD_K28_5     10'h1bc
`define SRD_ALL_ONES  10'h3ff
`define SRD_COMMA_P   7'h1f
`define SRD_COMMA_M   7'h60
`define SRD_FR_SAMPLE 4'h8
`endif

/* srd_pkg.sv */
// srd_pkg.sv: types shared by the device end and the framer end.
// assumes nothing of its surroundings.
package srd_pkg;
    typedef logic [1:0] srd_eq_t;

    typedef struct packed {
        logic    tx_up_n;
        logic    rx_up_n;
        logic    raw;
        logic    dir;
        logic    align;
        logic    tx_lock;
        logic    rx_lock;
        logic    ref_tb;
        srd_eq_t eq;
        logic    sin;
        logic    rxs;
        logic    txs;
    } srd_pins_s;

    typedef struct packed {
        srd_pins_s  s1;
        srd_pins_s  s2;
        logic [9:0] d1;
        logic [9:0] d2;
        logic       txs_p;
        logic       ref_p;
        logic       rxs_p;
        logic [7:0] miss;
        logic       ovf;
        logic [3:0] tbc;
        logic [9:0] tsh;
        logic       trd;
        logic       sout;
        logic       bias;
        logic [9:0] rsh;
        logic [3:0] rbc;
        logic       rrd;
        logic [9:0] rw;
        logic       rcom;
        logic       rnew;
        logic [9:0] wo;
        logic       so;
        logic       co;
        logic       uo;
        logic       lo;
        logic [2:0] sc;
        logic       sys;
        logic       adj;
        srd_eq_t    eqo;
    } srd_dev_s;

    typedef struct packed {
        logic [3:0] wc;
        logic       ts;
        logic       rs;
        logic [9:0] td;
        logic       raw;
        logic       dir;
        logic       align;
        logic       tx_up_n;
        logic       rx_up_n;
        logic       rsp;
        logic       rv;
        logic [9:0] rw;
        logic       rc;
        logic       ru;
        logic       rl;
    } srd_fr_s;
endpackage : srd_pkg

/* srd_link_if.sv */
// srd_link_if.sv: parallel buses and strobes between framer and device.
// assumes both ends run on one mclk; shared strobe resolved from enables.
`timescale 1ns/1ps
interface srd_link_if;
    logic [9:0] tx_parallel_word;
    logic       tx_word_strobe;
    logic [9:0] rx_parallel_word;
    logic       rx_word_oe;
    logic [9:0] rx_word_level;
    logic       rx_strobe_dev_o;
    logic       rx_strobe_dev_oe;
    logic       rx_strobe_fr_o;
    logic       rx_strobe_fr_oe;
    logic       rx_word_strobe;
    logic       comma_seen_flag;
    logic       rx_pll_unlocked;
    logic       signal_loss_flag;
    logic       raw_ten_bit_select;
    logic       rx_strobe_direction;
    logic       comma_align_allow;
    logic       tx_power_up_n;
    logic       rx_power_up_n;

    // device wins a contention, an undriven wire reads low
    assign rx_word_strobe = rx_strobe_dev_oe ? rx_strobe_dev_o
                          : (rx_strobe_fr_oe & rx_strobe_fr_o);
    assign rx_word_level  = rx_word_oe ? rx_parallel_word : 10'h000;

    modport dev (
        input  tx_parallel_word, tx_word_strobe, rx_word_strobe,
               raw_ten_bit_select, rx_strobe_direction,
               comma_align_allow, tx_power_up_n, rx_power_up_n,
        output rx_parallel_word, rx_word_oe, rx_strobe_dev_o,
               rx_strobe_dev_oe, comma_seen_flag, rx_pll_unlocked,
               signal_loss_flag
    );
    modport fr (
        output tx_parallel_word, tx_word_strobe, rx_strobe_fr_o,
               rx_strobe_fr_oe, raw_ten_bit_select, rx_strobe_direction,
               comma_align_allow, tx_power_up_n, rx_power_up_n,
        input  rx_word_level, rx_word_strobe, comma_seen_flag,
               rx_pll_unlocked, signal_loss_flag
    );
endinterface : srd_link_if

/* srd_fifo.sv */
// srd_fifo.sv: synchronous word fifo with valid/ready on both sides.
// assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
module srd_fifo #(
    parameter int W = 10,
    parameter int D = 8
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    import srd_pkg::*;
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } fifo_s;

    fifo_s st_r, st_nxt;
    logic  push, pop;

    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(D - 1)) ? '0 : p + AW'(1);
    endfunction : step

    assign in_ready  = st_r.cnt != (AW + 1)'(D);
    assign out_valid = st_r.cnt != '0;
    assign out_data  = st_r.mem[st_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = step(st_r.wp);
        end
        if (pop) begin
            st_nxt.rp = step(st_r.rp);
        end
        st_nxt.cnt = st_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        if (flush) begin
            st_nxt.wp  = '0;
            st_nxt.rp  = '0;
            st_nxt.cnt = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : srd_fifo

/* srd_device.sv */
// srd_device.sv: device end; 8b/10b coder, serializer, deserializer with
// comma alignment, receive bus muxing, lock flag and system timebase.
// assumes link pins and analog status pins are asynchronous to mclk and
// the serial line carries one bit per mclk, first bit coded bit 9.
//
// Overview of operation
// - tx off/unlocked biases line; missing strobe sends one
// - bad K or fifo error sends K30.7/zero
// - equalizer from pins, management when pins zero
// - one receive word per strobe edge
// - decoded mode: data, D/K flag, error flag
// - raw select gives undecoded ten-bit words
// - rx off tristates; unlocked: reference strobe, ones
// - locked: recovered strobe, words, locked timebase
// - write mode: device drives strobe, outputs follow it
// - read mode: outputs launched on partner strobe
// - partner read strobe runs at word rate
// - partner holds strobes static while synchronizing
// - timebase free-runs, then slips gently onto words
// - receive lock ignores the reference clock
// - unlocked flag high unlocked, low locked
// - code violations never touch the lock flag
// - coder covers all data and twelve K
// - invalid received groups decode to K30.7
// - comma realigns word boundary when allowed
// - partner decides when alignment is allowed
// - comma flag one word, only for a comma on the word boundary
// - partner maps data and D/K on input
`timescale 1ns/1ps
`include "srd_map.svh"
module srd_device (
    input  wire logic            mclk,
    input  wire logic            resetn,
    srd_link_if.dev              lk,
    input  wire logic            serial_line_in,
    output logic                 serial_line_out,
    output logic                 serial_line_bias,
    input  wire logic            tx_pll_locked,
    input  wire logic            rx_pll_locked,
    input  wire logic            reference_timebase,
    input  wire srd_pkg::srd_eq_t rx_equalizer_select,
    input  wire srd_pkg::srd_eq_t eq_mgmt_setting,
    output srd_pkg::srd_eq_t     rx_eq_effective,
    input  wire logic            signal_loss_detect,
    output logic                 recovered_system_timebase,
    output logic                 sys_timebase_oe,
    output logic                 tx_fifo_ready
);
    import srd_pkg::*;

    localparam logic [5:0] T6 [32] = '{
        6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
        6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] T4 [8] = '{
        4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

    srd_dev_s   st_r, st_nxt;
    srd_pins_s  pins;
    logic       tx_edge, miss, tx_on, tx_run, f_in_rdy, f_vld, f_pop;
    logic       err, rx_lk, ctop, bnd, ev;
    logic [9:0] f_out, code, sh;
    logic [8:0] kd;
    logic [10:0] e, d;

    // returns {rd_out, abcdei, fghj}; K words at rd+ are full complements
    function automatic logic [10:0] enc(input logic [8:0] k,
                                        input logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic [4:0] x;
        logic [2:0] y;
        logic       ri, r1, r2, a7;
        x  = k[4:0];
        y  = k[7:5];
        ri = rd & ~k[8];
        c6 = (k[8] && x == 5'h1c) ? 6'h0f : T6[x];
        r1 = ri;
        if ($countones(c6) != 3) begin
            c6 = ri ? ~c6 : c6;
            r1 = ~ri;
        end else if (x == 5'h07 && ri) begin
            c6 = 6'h07;
        end
        a7 = (y == 3'h7) && (k[8]
             || (!r1 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
             || (r1 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
        c4 = a7 ? 4'h7 : T4[y];
        r2 = r1;
        if ($countones(c4) != 2) begin
            c4 = r1 ? ~c4 : c4;
            r2 = ~r1;
        end else if (y == 3'h3 && r1) begin
            c4 = 4'h3;
        end
        enc = (k[8] && rd) ? ~{r2, c6, c4} : {r2, c6, c4};
    endfunction : enc

    function automatic logic valid_kd(input logic [8:0] k);
        valid_kd = !k[8] || k[4:0] == 5'h1c
                   || (k[7:5] == 3'h7 && (k[4:0] == 5'h17
                   || k[4:0] == 5'h1b || k[4:0] == 5'h1d
                   || k[4:0] == 5'h1e));
    endfunction : valid_kd

    // returns {rd_out, error, D/K, data}
    function automatic logic [10:0] dec(input logic [9:0] w,
                                        input logic rd);
        logic [10:0] e0, e1;
        logic [8:0]  k;
        logic        hit;
        dec = {rd, 1'b1, `SRD_K30_7};
        hit = 1'b0;
        for (int i = 0; i < 512; i++) begin
            k  = 9'(i);
            e0 = enc(k, rd);
            e1 = enc(k, ~rd);
            if (valid_kd(k) && e0[9:0] == w) begin
                dec = {e0[10], 1'b0, k};
                hit = 1'b1;
            end else if (valid_kd(k) && e1[9:0] == w && !hit) begin
                dec = {e1[10], 1'b1, k};
            end
        end
    endfunction : dec

    assign pins = '{tx_up_n: lk.tx_power_up_n, rx_up_n: lk.rx_power_up_n,
                    raw: lk.raw_ten_bit_select,
                    dir: lk.rx_strobe_direction,
                    align: lk.comma_align_allow, tx_lock: tx_pll_locked,
                    rx_lock: rx_pll_locked, ref_tb: reference_timebase,
                    eq: rx_equalizer_select, sin: serial_line_in,
                    rxs: lk.rx_word_strobe, txs: lk.tx_word_strobe};

    srd_fifo #(.W(10), .D(8)) u_txq (
        .mclk      (mclk),
        .resetn    (resetn),
        .flush     (!tx_run),
        .in_valid  (tx_edge),
        .in_ready  (f_in_rdy),
        .in_data   (st_r.d2),
        .out_valid (f_vld),
        .out_ready (f_pop),
        .out_data  (f_out)
    );

    always_comb begin
        st_nxt       = st_r;
        st_nxt.s1    = pins;
        st_nxt.s2    = st_r.s1;
        st_nxt.d1    = lk.tx_parallel_word;
        st_nxt.d2    = st_r.d1;
        st_nxt.txs_p = st_r.s2.txs;
        st_nxt.ref_p = st_r.s2.ref_tb;
        st_nxt.rxs_p = st_r.s2.rxs;
        // transmit: capture on both strobe edges, serialize every 10 clocks
        tx_edge = st_r.s2.txs != st_r.txs_p;
        miss    = st_r.miss >= `SRD_MISS_CYC;
        st_nxt.miss = tx_edge ? 8'h00 : (miss ? st_r.miss
                                              : st_r.miss + 8'h01);
        tx_on  = st_r.s2.tx_up_n && st_r.s2.tx_lock;
        tx_run = tx_on && !miss;
        f_pop  = tx_run && st_r.tbc == 4'h0;
        err    = !f_vld || st_r.ovf;
        kd     = (err || !valid_kd(f_out[8:0])) ? `SRD_K30_7
                                                 : f_out[8:0];
        e      = enc(kd, st_r.trd);
        code   = st_r.s2.raw ? (err ? 10'h000 : f_out) : e[9:0];
        if (f_pop) begin
            st_nxt.ovf  = 1'b0;
            st_nxt.tsh  = code;
            st_nxt.tbc  = `SRD_LAST_BIT;
            st_nxt.trd  = st_r.s2.raw ? st_r.trd : e[10];
            st_nxt.sout = code[9];
        end else if (st_r.tbc != 4'h0) begin
            st_nxt.tsh  = {st_r.tsh[8:0], 1'b0};
            st_nxt.tbc  = st_r.tbc - 4'h1;
            st_nxt.sout = st_r.tsh[8];
        end
        if (tx_edge && !f_in_rdy) begin
            st_nxt.ovf = 1'b1;
        end
        st_nxt.bias = !tx_on;
        if (!tx_on) begin
            st_nxt.sout = 1'b0;
            st_nxt.tbc  = 4'h0;
        end else if (miss) begin
            st_nxt.sout = 1'b1;
            st_nxt.tbc  = 4'h0;
        end
        // receive: deserialize, align on comma, decode at each boundary
        rx_lk = st_r.s2.rx_up_n && st_r.s2.rx_lock;
        sh    = {st_r.rsh[8:0], st_r.s2.sin};
        ctop  = sh[9:3] == `SRD_COMMA_P || sh[9:3] == `SRD_COMMA_M;
        bnd   = st_r.rbc == `SRD_LAST_BIT || (st_r.s2.align && ctop);
        d     = dec(sh, st_r.rrd);
        st_nxt.rsh  = sh;
        st_nxt.rbc  = bnd ? 4'h0 : st_r.rbc + 4'h1;
        st_nxt.rnew = bnd && rx_lk;
        if (bnd) begin
            st_nxt.rrd  = d[10];
            st_nxt.rw   = st_r.s2.raw ? sh : d[9:0];
            st_nxt.rcom = ctop;
        end
        // launch event: partner strobe edge, word, or reference edge
        if (st_r.s2.dir) begin
            ev = st_r.s2.rxs != st_r.rxs_p;
        end else begin
            ev = rx_lk ? st_r.rnew
                       : st_r.s2.ref_tb != st_r.ref_p;
        end
        if (ev) begin
            st_nxt.wo = rx_lk ? st_r.rw : `SRD_ALL_ONES;
            st_nxt.co = rx_lk && st_r.rcom;
            st_nxt.uo = !st_r.s2.rx_lock;
            st_nxt.lo = signal_loss_detect;
            st_nxt.so = ~st_r.so;
        end
        // system timebase: free divider, slips one clock per half period
        if (!rx_lk) begin
            st_nxt.adj = 1'b0;
        end else if (st_r.rnew && st_r.sc != 3'h0) begin
            st_nxt.adj = 1'b1;
        end
        if (st_r.sc == `SRD_SYS_HALF - 3'h1) begin
            if (st_r.adj && rx_lk) begin
                st_nxt.adj = 1'b0;
            end else begin
                st_nxt.sc  = 3'h0;
                st_nxt.sys = ~st_r.sys;
            end
        end else begin
            st_nxt.sc = st_r.sc + 3'h1;
        end
        st_nxt.eqo = (st_r.s2.eq == 2'h0) ? eq_mgmt_setting
                                          : st_r.s2.eq;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_r      <= '0;
            st_r.uo   <= 1'b1;
            st_r.bias <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lk.rx_parallel_word = st_r.wo;
    assign lk.rx_word_oe       = st_r.s2.rx_up_n;
    assign lk.rx_strobe_dev_o  = st_r.so;
    assign lk.rx_strobe_dev_oe = st_r.s2.rx_up_n && !st_r.s2.dir;
    assign lk.comma_seen_flag  = st_r.co;
    assign lk.rx_pll_unlocked  = st_r.uo;
    assign lk.signal_loss_flag = st_r.lo;
    assign serial_line_out     = st_r.sout;
    assign serial_line_bias    = st_r.bias;
    assign rx_eq_effective     = st_r.eqo;
    assign recovered_system_timebase = st_r.sys;
    assign sys_timebase_oe     = st_r.s2.rx_up_n;
    assign tx_fifo_ready       = f_in_rdy;
endmodule : srd_device

/* srd_framer.sv */
// srd_framer.sv: framer end; drives the transmit bus and strobe, the
// configuration pins and in read mode the receive strobe; samples the
// receive bus. assumes device outputs are registered on the same mclk.
`timescale 1ns/1ps
`include "srd_map.svh"
module srd_framer (
    input  wire logic       mclk,
    input  wire logic       resetn,
    srd_link_if.fr          lk,
    input  wire logic       cfg_raw,
    input  wire logic       cfg_dir,
    input  wire logic       cfg_align,
    input  wire logic       cfg_tx_power_up_n,
    input  wire logic       cfg_rx_power_up_n,
    input  wire logic       sync_hold,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [9:0] tx_word,
    output logic            rx_valid,
    output logic [9:0]      rx_word,
    output logic            rx_comma,
    output logic            rx_unlocked,
    output logic            rx_loss
);
    import srd_pkg::*;

    srd_fr_s st_r, st_nxt;
    logic    take;

    assign tx_ready = st_r.wc == `SRD_LAST_BIT && !sync_hold;

    always_comb begin
        st_nxt         = st_r;
        st_nxt.raw     = cfg_raw;
        st_nxt.dir     = cfg_dir;
        st_nxt.align   = cfg_align;
        st_nxt.tx_up_n = cfg_tx_power_up_n;
        st_nxt.rx_up_n = cfg_rx_power_up_n;
        st_nxt.wc = (st_r.wc == `SRD_LAST_BIT) ? 4'h0 : st_r.wc + 4'h1;
        if (tx_ready) begin
            st_nxt.td = tx_valid ? tx_word : `SRD_K28_5;
            if (!st_r.raw) begin
                st_nxt.td[9] = 1'b0;
            end
        end
        // transmit strobe toggles once per word, receive strobe too in read mode; both stand still while held
        if (st_r.wc == 4'h0 && !sync_hold) begin
            st_nxt.ts = ~st_r.ts;
            if (st_r.dir) begin
                st_nxt.rs = ~st_r.rs;
            end
        end
        st_nxt.rsp = lk.rx_word_strobe;
        if (st_r.dir) begin
            take = st_r.wc == `SRD_FR_SAMPLE && !sync_hold;
        end else begin
            take = lk.rx_word_strobe != st_r.rsp;
        end
        st_nxt.rv = take;
        if (take) begin
            st_nxt.rw = lk.rx_word_level;
            st_nxt.rc = lk.comma_seen_flag;
            st_nxt.ru = lk.rx_pll_unlocked;
            st_nxt.rl = lk.signal_loss_flag;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lk.tx_parallel_word    = st_r.td;
    assign lk.tx_word_strobe      = st_r.ts;
    assign lk.rx_strobe_fr_o      = st_r.rs;
    assign lk.rx_strobe_fr_oe     = st_r.dir;
    assign lk.raw_ten_bit_select  = st_r.raw;
    assign lk.rx_strobe_direction = st_r.dir;
    assign lk.comma_align_allow   = st_r.align;
    assign lk.tx_power_up_n       = st_r.tx_up_n;
    assign lk.rx_power_up_n       = st_r.rx_up_n;
    assign rx_valid    = st_r.rv;
    assign rx_word     = st_r.rw;
    assign rx_comma    = st_r.rc;
    assign rx_unlocked = st_r.ru;
    assign rx_loss     = st_r.rl;
endmodule : srd_framer

/* srd_link_chk.sv */
// srd_link_chk.sv: assertions on the receive side of the link.
// assumes one mclk domain; instantiated beside the link interface.
`timescale 1ns/1ps
module srd_link_chk (
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic [9:0] rx_parallel_word,
    input wire logic       rx_word_oe,
    input wire logic       rx_strobe_dev_o,
    input wire logic       rx_strobe_dev_oe,
    input wire logic       rx_word_strobe,
    input wire logic       comma_seen_flag,
    input wire logic       rx_pll_unlocked,
    input wire logic       raw_ten_bit_select,
    input wire logic       rx_strobe_direction,
    input wire logic       rx_power_up_n
);
    logic [5:0] age_r;
    logic [2:0] edge_r;
    logic       so_r, oe_r, wr_ok, wr_edge;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // write mode with the device driving the strobe now and last cycle
    assign wr_ok   = !rx_strobe_direction && rx_strobe_dev_oe && oe_r;
    assign wr_edge = wr_ok && (rx_strobe_dev_o != so_r);
    // age: cycles since a mode pin moved; edge: since the strobe moved
    always_ff @(posedge mclk) begin
        so_r <= rx_strobe_dev_o;
        oe_r <= resetn && rx_strobe_dev_oe;
        if (!resetn || $changed(raw_ten_bit_select)
                    || $changed(rx_strobe_direction))
            age_r <= 6'h00;
        else if (age_r != 6'h3f)
            age_r <= age_r + 6'h01;
        if (!resetn || $changed(rx_word_strobe))
            edge_r <= 3'h0;
        else if (edge_r != 3'h7)
            edge_r <= edge_r + 3'h1;
    end
    chk_bus_oe_power: assert property (
        $stable(rx_power_up_n) [*4] |-> rx_word_oe == rx_power_up_n)
        else $error("bus enable does not follow receive power");
    chk_strobe_drive_dir: assert property (
        ($stable(rx_strobe_direction) && $stable(rx_power_up_n)) [*4]
        |-> rx_strobe_dev_oe == (rx_power_up_n && !rx_strobe_direction))
        else $error("strobe enable wrong for direction");
    chk_word_on_strobe: assert property (
        wr_ok && $changed(rx_parallel_word) |-> wr_edge)
        else $error("receive word moved without a strobe edge");
    chk_comma_on_strobe: assert property (
        wr_ok && $changed(comma_seen_flag) |-> wr_edge)
        else $error("comma flag moved without a strobe edge");
    chk_lock_on_strobe: assert property (
        wr_ok && $changed(rx_pll_unlocked) |-> wr_edge)
        else $error("lock flag moved without a strobe edge");
    chk_unlocked_ones: assert property (
        wr_edge && rx_pll_unlocked
        |-> rx_parallel_word == 10'h3ff && !comma_seen_flag)
        else $error("unlocked launch is not all ones");
    chk_comma_decode: assert property (
        age_r == 6'h3f && !raw_ten_bit_select && !rx_pll_unlocked
        && comma_seen_flag |-> rx_parallel_word[8:0] inside
        {9'h13c, 9'h1bc, 9'h1fc, 9'h1fe})
        else $error("comma flag on a word without a comma");
    chk_read_launch: assert property (
        age_r == 6'h3f && rx_strobe_direction && rx_word_oe
        && $changed(rx_parallel_word) |-> edge_r inside {[3'h1:3'h4]})
        else $error("read mode word not launched after strobe edge");
    cover property (wr_edge && comma_seen_flag && !rx_pll_unlocked);
    cover property (wr_edge && rx_pll_unlocked);
    cover property (rx_strobe_direction && $changed(rx_parallel_word));
endmodule : srd_link_chk

/* testbench.sv */
// testbench.sv: framer and device joined, serial line looped back.
// assumes the design files and srd_link_chk.sv are compiled before it.
`timescale 1ns/1ps
module testbench;
    import srd_pkg::*;
    logic        mclk = 1'b0;
    logic        ref_tb = 1'b0;
    logic        resetn, line, bias, sys_oe, rv, rc, ru, sysb, sys0, txq_rdy;
    logic        raw, dir, align, tpu, rpu, hold, tv, tr, txl, rxl;
    logic [9:0]  tw, rw;
    srd_eq_t     eq_sel, eq_eff;
    int          err_count, tests_run, i;
    // sent word, decoded word, comma flag
    logic [20:0] rows [16] = '{
        {10'h000, 10'h000, 1'b0}, {10'h0ff, 10'h0ff, 1'b0},
        {10'h055, 10'h055, 1'b0}, {10'h0a3, 10'h0a3, 1'b0},
        {10'h1f7, 10'h1f7, 1'b0}, {10'h1fb, 10'h1fb, 1'b0},
        {10'h11c, 10'h11c, 1'b0}, {10'h13c, 10'h13c, 1'b1},
        {10'h15c, 10'h15c, 1'b0}, {10'h17c, 10'h17c, 1'b0},
        {10'h19c, 10'h19c, 1'b0}, {10'h1dc, 10'h1dc, 1'b0},
        {10'h1fc, 10'h1fc, 1'b1}, {10'h1fd, 10'h1fd, 1'b0},
        {10'h1fe, 10'h1fe, 1'b0}, {10'h100, 10'h1fe, 1'b0}};
    srd_link_if lk_if ();
    srd_device srd_device_i (.mclk(mclk), .resetn(resetn), .lk(lk_if),
        .serial_line_in(line), .serial_line_out(line),
        .serial_line_bias(bias), .tx_pll_locked(txl), .rx_pll_locked(rxl),
        .reference_timebase(ref_tb), .rx_equalizer_select(eq_sel),
        .eq_mgmt_setting(2'h2), .rx_eq_effective(eq_eff),
        .signal_loss_detect(1'b0), .recovered_system_timebase(sysb),
        .sys_timebase_oe(sys_oe), .tx_fifo_ready(txq_rdy));
    srd_framer srd_framer_i (.mclk(mclk), .resetn(resetn), .lk(lk_if),
        .cfg_raw(raw), .cfg_dir(dir), .cfg_align(align),
        .cfg_tx_power_up_n(tpu), .cfg_rx_power_up_n(rpu),
        .sync_hold(hold), .tx_valid(tv), .tx_ready(tr), .tx_word(tw),
        .rx_valid(rv), .rx_word(rw), .rx_comma(rc), .rx_unlocked(ru),
        .rx_loss());
    srd_link_chk srd_link_chk_i (.mclk(mclk), .resetn(resetn),
        .rx_parallel_word(lk_if.rx_parallel_word),
        .rx_word_oe(lk_if.rx_word_oe), .rx_word_strobe(lk_if.rx_word_strobe),
        .rx_strobe_dev_o(lk_if.rx_strobe_dev_o),
        .rx_strobe_dev_oe(lk_if.rx_strobe_dev_oe),
        .comma_seen_flag(lk_if.comma_seen_flag),
        .rx_pll_unlocked(lk_if.rx_pll_unlocked),
        .raw_ten_bit_select(lk_if.raw_ten_bit_select),
        .rx_strobe_direction(lk_if.rx_strobe_direction),
        .rx_power_up_n(lk_if.rx_power_up_n));
    always #2 mclk = ~mclk;
    always #16.276 ref_tb = ~ref_tb;
    task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // hold the word up until the framer takes it
    task automatic send(input logic [9:0] t);
        int k;
        tw = t;
        tv = 1'b1;
        for (k = 0; k < 40 && tr !== 1'b1; k++) @(negedge mclk);
        if (k == 40) begin
            err_count++;
            end_of_test();
        end
        @(negedge mclk);
        tv = 1'b0;
    endtask : send
    // first received word other than the idle comma
    task automatic expect_rx(input logic [9:0] e, input logic c);
        int k;
        for (k = 0; k < 400; k++) begin
            @(negedge mclk);
            if (rv === 1'b1 && rw !== 10'h1bc) break;
        end
        if (k == 400) begin
            err_count++;
            end_of_test();
        end
        cmp(rw, e);
        cmp({9'h0, rc}, {9'h0, c});
    endtask : expect_rx
    initial begin
        {resetn, raw, dir, align, hold, tv, txl, rxl} = '0;
        {tpu, rpu, tw, eq_sel} = 14'h3000;
        err_count = 0;
        tests_run = 0;
        repeat (4) @(negedge mclk);
        cmp({9'h0, bias}, 10'h001);
        cmp({9'h0, lk_if.rx_pll_unlocked}, 10'h001);
        resetn = 1'b1;
        repeat (100) @(negedge mclk);
        cmp({7'h0, txq_rdy, bias, line}, 10'h006);
        expect_rx(10'h3ff, 1'b0);
        cmp({9'h0, ru}, 10'h001);
        // free-running timebase: half period of 4 clocks
        sys0 = sysb;
        repeat (4) @(negedge mclk);
        cmp({9'h0, sysb}, {9'h0, ~sys0});
        {txl, rxl, align} = 3'b111;
        repeat (400) @(negedge mclk);
        align = 1'b0;
        repeat (40) @(negedge mclk);
        for (i = 0; i < 16; i++) begin
            send(rows[i][20:11]);
            expect_rx(rows[i][10:1], rows[i][0]);
        end
        cmp({9'h0, ru}, 10'h000);
        raw = 1'b1;
        repeat (100) @(negedge mclk);
        send(10'h2a5);
        expect_rx(10'h2a5, 1'b0);
        {raw, dir} = 2'b01;
        repeat (100) @(negedge mclk);
        send(10'h0c3);
        expect_rx(10'h0c3, 1'b0);
        dir = 1'b0;
        for (i = 0; i < 4; i++) begin
            eq_sel = i[1:0];
            repeat (6) @(negedge mclk);
            cmp({8'h0, eq_eff}, (i == 0) ? 10'h002 : 10'(i));
        end
        {tpu, align} = 2'b01;
        repeat (10) @(negedge mclk);
        cmp({8'h0, bias, line}, 10'h002);
        {tpu, hold} = 2'b11;
        repeat (170) @(negedge mclk);
        cmp({8'h0, bias, line}, 10'h001);
        hold = 1'b0;
        repeat (200) @(negedge mclk);
        send(10'h01e);
        expect_rx(10'h01e, 1'b0);
        rpu = 1'b0;
        repeat (10) @(negedge mclk);
        cmp({8'h0, lk_if.rx_word_oe, sys_oe}, 10'h000);
        cmp(lk_if.rx_word_level, 10'h000);
        end_of_test();
    end
endmodule : testbench
